// ==== verilog/psm_panel_top.sv ====
// Panel status/monitor display: package of constants and types,
// then the top module that runs boot, monitor, edit, save result and alarm views.
// Assumes keys arrive from pins, and that the parameter store answers combinationally.
// Behaviour
// R1: Save shows outcome indication about one second
// R2: Successful store shows saved-correctly indication
// R3: Read-only target rejected, write-protected indication
// R4: Wrong or missing password shows locked
// R5: Invalid or reserved value shows out-of-range
// R6: Servo energized blocks flagged parameters, servo-on
// R7: Repower-needed parameter shows power-on after save
// R8: Decimal point marks high or low half
// R9: Decimal negatives light two left points; hex unsigned
// R10: Drive error shows alarm prefix plus code
// R11: Up/down step blinking digit; shift moves it
// R12: Shift held two seconds toggles sign, range-checked
// R13: Power-up shows monitor symbol one second
// R14: Up/down step monitors; setting selects directly
// R15: Codes 0-2: user-unit feedback, command, error
// R16: Codes 3-5: encoder-unit pulses, 1600000 per rev
// R17: Codes 6-11: frequency, speed, speed/torque commands
// R18: Codes 12-16: loads, voltage, inertia tenths, temperature
// R19: Code 17: resonances, low first, high second
// R20: Code 18: index-relative position within +/-5000
// R21: New alarm forces alarm view; 20 s idle returns
// R22: Monitor select above 18 keeps old choice
`timescale 1ns/1ps
`default_nettype none

package psm_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SHOW_MS = 1000;
  localparam int unsigned HOLD_MS = 2000;
  localparam int unsigned IDLE_S = 20;
  localparam int unsigned BLINK_MS = 250;
  localparam int unsigned SHOW_CYC = int'(64'(SHOW_MS) * 64'(CLK_HZ) / 64'd1000);
  localparam int unsigned HOLD_CYC = int'(64'(HOLD_MS) * 64'(CLK_HZ) / 64'd1000);
  localparam int unsigned IDLE_CYC = int'(64'(IDLE_S) * 64'(CLK_HZ));
  localparam int unsigned BLINK_CYC = int'(64'(BLINK_MS) * 64'(CLK_HZ) / 64'd1000);

  // Monitor codes
  localparam logic [4:0] MON_FB_UU = 5'h00;
  localparam logic [4:0] MON_CMD_UU = 5'h01;
  localparam logic [4:0] MON_ERR_UU = 5'h02;
  localparam logic [4:0] MON_FB_PLS = 5'h03;
  localparam logic [4:0] MON_CMD_PLS = 5'h04;
  localparam logic [4:0] MON_ERR_PLS = 5'h05;
  localparam logic [4:0] MON_CMD_KPPS = 5'h06;
  localparam logic [4:0] MON_SPEED = 5'h07;
  localparam logic [4:0] MON_SPD_VOLT = 5'h08;
  localparam logic [4:0] MON_SPD_RPM = 5'h09;
  localparam logic [4:0] MON_TRQ_VOLT = 5'h0a;
  localparam logic [4:0] MON_TRQ_PCT = 5'h0b;
  localparam logic [4:0] MON_LOAD_AVG = 5'h0c;
  localparam logic [4:0] MON_LOAD_PEAK = 5'h0d;
  localparam logic [4:0] MON_BUS_VOLT = 5'h0e;
  localparam logic [4:0] MON_INERTIA = 5'h0f;
  localparam logic [4:0] MON_TEMP = 5'h10;
  localparam logic [4:0] MON_RESON = 5'h11;
  localparam logic [4:0] MON_INDEX_POS = 5'h12;
  localparam logic [4:0] MON_LAST = MON_INDEX_POS;
  localparam logic [4:0] MON_RESET = MON_FB_UU;
  localparam int ENC_PPR = 1600000;
  localparam int INDEX_SPAN = 5000;
  localparam int INERTIA_DIV = 10;

  // Save result codes
  localparam logic [2:0] RES_SAVED = 3'h0;
  localparam logic [2:0] RES_RO = 3'h1;
  localparam logic [2:0] RES_LOCK = 3'h2;
  localparam logic [2:0] RES_OOR = 3'h3;
  localparam logic [2:0] RES_SON = 3'h4;
  localparam logic [2:0] RES_PON = 3'h5;

  // Segments {dp,g,f,e,d,c,b,a}
  localparam logic [7:0] SEG_DP = 8'h80;
  localparam logic [7:0] SEG_BLANK = 8'h00;
  localparam logic [7:0] SEG_MINUS = 8'h40;
  localparam logic [7:0] SEG_A = 8'h77;
  localparam logic [7:0] SEG_L = 8'h38;
  localparam logic [7:0] SEG_H = 8'h74;
  localparam logic [7:0] SEG_P = 8'h73;
  localparam logic [7:0] SEG_N = 8'h54;
  localparam logic [39:0] TXT_SAVED = 40'h6d_77_1c_79_5e;
  localparam logic [39:0] TXT_RO = 40'h50_40_3f_38_6e;
  localparam logic [39:0] TXT_LOCK = 40'h38_5c_58_76_5e;
  localparam logic [39:0] TXT_OOR = 40'h3f_1c_78_40_50;
  localparam logic [39:0] TXT_SON = 40'h6d_50_40_5c_54;
  localparam logic [39:0] TXT_PON = 40'h73_5c_40_5c_54;

  typedef logic [4:0][7:0] psm_glyphs_t;
  typedef struct packed {
    logic mode;
    logic set;
    logic shift;
    logic up;
    logic down;
  } psm_keys_s;
  typedef struct packed {
    logic read_only;
    logic run_locked;
    logic repower;
    logic is32;
    logic hex;
    logic signed [31:0] min;
    logic signed [31:0] max;
  } psm_attr_s;

  function automatic logic [7:0] hex_seg(input logic [3:0] h);
    logic [7:0] s;
    s = SEG_BLANK;
    case (h)
      4'h0: s = 8'h3f;
      4'h1: s = 8'h06;
      4'h2: s = 8'h5b;
      4'h3: s = 8'h4f;
      4'h4: s = 8'h66;
      4'h5: s = 8'h6d;
      4'h6: s = 8'h7d;
      4'h7: s = 8'h07;
      4'h8: s = 8'h7f;
      4'h9: s = 8'h6f;
      4'ha: s = 8'h77;
      4'hb: s = 8'h7c;
      4'hc: s = 8'h39;
      4'hd: s = 8'h5e;
      4'he: s = 8'h79;
      default: s = 8'h71;
    endcase
    return s;
  endfunction
endpackage

module psm_panel_top #(
  parameter int unsigned P_SHOW_CYC = psm_pkg::SHOW_CYC,
  parameter int unsigned P_HOLD_CYC = psm_pkg::HOLD_CYC,
  parameter int unsigned P_IDLE_CYC = psm_pkg::IDLE_CYC,
  parameter int unsigned P_BLINK_CYC = psm_pkg::BLINK_CYC
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire psm_pkg::psm_keys_s i_keys,
  input wire logic i_edit_start,
  input wire logic signed [31:0] i_edit_init,
  input wire psm_pkg::psm_attr_s i_attr,
  input wire logic i_pw_ok,
  input wire logic i_servo_on,
  input wire logic i_val_reserved,
  input wire logic i_alarm_new,
  input wire logic i_alarm_act,
  input wire logic [11:0] i_alarm_code,
  input wire logic i_msel_wr,
  input wire logic [7:0] i_msel_data,
  input wire logic signed [31:0] i_mon_value,
  output logic [4:0] o_mon_sel,
  output logic o_wr_stb,
  output logic signed [31:0] o_wr_value,
  output logic o_alarm_view,
  output psm_pkg::psm_glyphs_t o_seg
);
  typedef enum logic [4:0] {
    ST_BOOT = 5'b00001,
    ST_MON = 5'b00010,
    ST_EDIT = 5'b00100,
    ST_RES = 5'b01000,
    ST_ALM = 5'b10000
  } psm_state_e;

  function automatic logic signed [31:0] pow10(input logic [2:0] d);
    logic signed [31:0] p;
    p = 32'sd1;
    for (int i = 0; i < 4; i++) begin
      if (i < int'(d)) begin
        p = p * 32'sd10;
      end
    end
    return p;
  endfunction

  function automatic logic in_range(input logic signed [31:0] v, input psm_pkg::psm_attr_s a);
    return (v >= a.min) && (v <= a.max);
  endfunction

  psm_state_e st_q, st_d;
  psm_pkg::psm_keys_s ks1_q, ks2_q, ks3_q, press, rel;
  logic [31:0] t_q, idle_q, hold_q, blk_q;
  logic blink_q, hold_done_q, hex_q, hi_q;
  logic [4:0] sel_q;
  logic [2:0] dig_q, res_q, res_d;
  logic signed [31:0] ev_q;
  psm_pkg::psm_attr_s attr_q;
  logic save_go, save_ok, idle_hit, fmt_neg, fmt_32;
  psm_pkg::psm_glyphs_t fmt_seg, disp_d;

  // Keys come from pins: two flops, then an edge stage
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ks1_q <= '0;
      ks2_q <= '0;
      ks3_q <= '0;
    end else begin
      ks1_q <= i_keys;
      ks2_q <= ks1_q;
      ks3_q <= ks2_q;
    end
  end
  assign press = ks2_q & ~ks3_q;
  assign rel = ~ks2_q & ks3_q;

  assign idle_hit = i_alarm_act && (st_q != ST_ALM) && (idle_q >= P_IDLE_CYC - 1);
  // An alarm taking the view in the same cycle cancels the save; a mode press in that cycle does not, and its write goes unreported
  assign save_go = (st_q == ST_EDIT) && press.set && !i_alarm_new && !idle_hit;

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_BOOT: if (t_q >= P_SHOW_CYC - 1) st_d = ST_MON; // R13
      ST_MON: begin
        if (i_edit_start) begin
          st_d = ST_EDIT;
        end else if (press.mode && i_alarm_act) begin
          st_d = ST_ALM;
        end
      end
      ST_EDIT: begin
        if (press.mode) begin
          st_d = ST_MON;
        end else if (press.set) begin
          st_d = ST_RES; // R1
        end
      end
      ST_RES: if (t_q >= P_SHOW_CYC - 1) st_d = ST_MON; // R1
      ST_ALM: if (press.mode) st_d = ST_MON;
      default: st_d = ST_MON;
    endcase
    if (i_alarm_new || idle_hit) begin
      st_d = ST_ALM; // R21
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= ST_BOOT;
      t_q <= '0;
    end else begin
      st_q <= st_d;
      t_q <= (st_d != st_q) ? 32'h0 : t_q + 32'h1;
    end
  end

  // Idle time since the last key, for the alarm return
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      idle_q <= '0;
    end else if (|press || st_q == ST_ALM) begin
      idle_q <= '0;
    end else if (idle_q < P_IDLE_CYC - 1) begin
      idle_q <= idle_q + 32'h1; // R21
    end
  end

  // Blink divider for the edited digit
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      blk_q <= '0;
      blink_q <= 1'b1;
    end else if (blk_q >= P_BLINK_CYC - 1) begin
      blk_q <= '0;
      blink_q <= ~blink_q;
    end else begin
      blk_q <= blk_q + 32'h1;
    end
  end

  // Monitor selection
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sel_q <= psm_pkg::MON_RESET;
      hex_q <= 1'b0;
      hi_q <= 1'b0;
    end else begin
      if (i_msel_wr) begin
        if (i_msel_data <= 8'(psm_pkg::MON_LAST)) begin
          sel_q <= i_msel_data[4:0]; // R14
          hi_q <= 1'b0;
        end // R22
      end else if (st_q == ST_MON && press.up) begin
        sel_q <= (sel_q == psm_pkg::MON_LAST) ? 5'h0 : sel_q + 5'h1; // R14
        hi_q <= 1'b0;
      end else if (st_q == ST_MON && press.down) begin
        sel_q <= (sel_q == 5'h0) ? psm_pkg::MON_LAST : sel_q - 5'h1; // R14
        hi_q <= 1'b0;
      end else if (st_q == ST_MON && press.shift) begin
        hi_q <= ~hi_q; // R8
      end
      if (st_q == ST_MON && press.set) begin
        hex_q <= ~hex_q;
      end
    end
  end

  // Edit value, blinking digit and sign hold
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ev_q <= '0;
      attr_q <= '0;
      dig_q <= '0;
      hold_q <= '0;
      hold_done_q <= 1'b0;
    end else if (st_q == ST_MON && i_edit_start && !i_alarm_new) begin
      ev_q <= i_edit_init;
      attr_q <= i_attr;
      dig_q <= '0;
      hold_q <= '0;
      hold_done_q <= 1'b0;
    end else if (st_q == ST_EDIT) begin
      if (press.up) ev_q <= ev_q + pow10(dig_q); // R11
      else if (press.down) ev_q <= ev_q - pow10(dig_q); // R11
      if (ks2_q.shift) begin
        hold_q <= (hold_q < P_HOLD_CYC - 1) ? hold_q + 32'h1 : hold_q;
        if (hold_q == P_HOLD_CYC - 2 && !hold_done_q) begin
          hold_done_q <= 1'b1;
          if (in_range(-ev_q, attr_q)) ev_q <= -ev_q; // R12
        end
      end else begin
        hold_q <= '0;
        hold_done_q <= 1'b0;
      end
      // Short shift acts on release, so a long hold does not also move
      if (rel.shift && !hold_done_q) dig_q <= (dig_q == 3'h4) ? 3'h0 : dig_q + 3'h1; // R11
    end
  end

  // Save evaluation, most severe refusal first
  always_comb begin
    save_ok = 1'b0;
    if (attr_q.read_only) begin
      res_d = psm_pkg::RES_RO; // R3
    end else if (!i_pw_ok) begin
      res_d = psm_pkg::RES_LOCK; // R4
    end else if (i_servo_on && attr_q.run_locked) begin
      res_d = psm_pkg::RES_SON; // R6
    end else if (!in_range(ev_q, attr_q) || i_val_reserved) begin
      res_d = psm_pkg::RES_OOR; // R5
    end else begin
      save_ok = 1'b1;
      res_d = attr_q.repower ? psm_pkg::RES_PON : psm_pkg::RES_SAVED; // R7 R2
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      res_q <= psm_pkg::RES_SAVED;
      o_wr_stb <= 1'b0;
      o_wr_value <= '0;
    end else begin
      o_wr_stb <= save_go && save_ok;
      if (save_go) begin
        res_q <= res_d;
        o_wr_value <= ev_q;
      end
    end
  end

  // Codes 0-5 and 17 carry 32-bit data; 17 splits into two 16-bit fields
  assign fmt_32 = (st_q == ST_EDIT) ? attr_q.is32 :
                  (sel_q <= psm_pkg::MON_ERR_PLS) || (sel_q == psm_pkg::MON_RESON); // R15 R16 R17 R18 R19 R20

  psm_num_fmt psm_num_fmt_i (
    .i_value((st_q == ST_EDIT) ? ev_q : i_mon_value),
    .i_is32(fmt_32),
    .i_hex((st_q == ST_EDIT) ? attr_q.hex : hex_q),
    .i_high((st_q == ST_EDIT) ? 1'b0 : hi_q),
    .i_split((st_q != ST_EDIT) && (sel_q == psm_pkg::MON_RESON)),
    .o_seg(fmt_seg),
    .o_neg(fmt_neg)
  );

  always_comb begin
    disp_d = fmt_seg;
    case (st_q)
      ST_BOOT: begin
        disp_d = {psm_pkg::SEG_P, psm_pkg::SEG_N, psm_pkg::SEG_MINUS,
                  psm_pkg::hex_seg((sel_q >= 5'd10) ? 4'h1 : 4'h0),
                  psm_pkg::hex_seg(4'((sel_q >= 5'd10) ? sel_q - 5'd10 : sel_q))}; // R13
      end
      ST_EDIT: if (!blink_q) disp_d[dig_q] = psm_pkg::SEG_BLANK; // R11
      ST_RES: begin
        case (res_q)
          psm_pkg::RES_RO: disp_d = psm_pkg::TXT_RO;
          psm_pkg::RES_LOCK: disp_d = psm_pkg::TXT_LOCK;
          psm_pkg::RES_OOR: disp_d = psm_pkg::TXT_OOR;
          psm_pkg::RES_SON: disp_d = psm_pkg::TXT_SON;
          psm_pkg::RES_PON: disp_d = psm_pkg::TXT_PON;
          default: disp_d = psm_pkg::TXT_SAVED;
        endcase
      end
      ST_ALM: begin
        disp_d = {psm_pkg::SEG_A, psm_pkg::SEG_L, psm_pkg::hex_seg(i_alarm_code[11:8]),
                  psm_pkg::hex_seg(i_alarm_code[7:4]), psm_pkg::hex_seg(i_alarm_code[3:0])}; // R10
      end
      default: disp_d = fmt_seg;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_seg <= '0;
    end else begin
      o_seg <= disp_d;
    end
  end

  assign o_mon_sel = sel_q;
  assign o_alarm_view = (st_q == ST_ALM);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_save(logic cond);
    save_go && cond;
  endsequence
  sequence s_shown(logic [2:0] code);
    ##1 (st_q == ST_RES) && (res_q == code);
  endsequence

  result_hold_a: assert property ((st_q == ST_RES) && (t_q < P_SHOW_CYC - 1) && !i_alarm_new && !idle_hit
    |=> st_q == ST_RES) else $error("result view left early"); // R1
  saved_ok_a: assert property (s_save(save_ok && !attr_q.repower) |-> s_shown(psm_pkg::RES_SAVED) ##0 o_wr_stb)
    else $error("saved result missing"); // R2
  ro_reject_a: assert property (s_save(attr_q.read_only) |-> s_shown(psm_pkg::RES_RO) ##0 !o_wr_stb)
    else $error("read-only save not refused"); // R3
  lock_reject_a: assert property (s_save(!attr_q.read_only && !i_pw_ok) |-> s_shown(psm_pkg::RES_LOCK) ##0 !o_wr_stb)
    else $error("locked save not refused"); // R4
  servo_reject_a: assert property (s_save(!attr_q.read_only && i_pw_ok && i_servo_on && attr_q.run_locked)
    |-> s_shown(psm_pkg::RES_SON)) else $error("servo-on save not refused"); // R6
  power_on_a: assert property (s_save(save_ok && attr_q.repower) |-> s_shown(psm_pkg::RES_PON))
    else $error("power-on result missing"); // R7
  neg_point_a: assert property (fmt_neg && (st_q == ST_MON) |=> o_seg[4][7] && o_seg[3][7])
    else $error("negative points not lit"); // R9
  alarm_jump_a: assert property (i_alarm_new |=> (st_q == ST_ALM) ##1 o_seg[4] == psm_pkg::SEG_A)
    else $error("alarm view not entered"); // R21
  sel_keep_a: assert property (i_msel_wr && (i_msel_data > 8'(psm_pkg::MON_LAST)) |=> $stable(sel_q))
    else $error("bad monitor select taken"); // R22
endmodule

`default_nettype wire

// ==== verilog/psm_num_fmt.sv ====
// Number formatter: turns a value into five seven-segment glyphs,
// decimal or hex, 16 or 32 bits, with half and sign points.
// Assumes values arrive sign-extended to 32 bits; purely combinational.
`timescale 1ns/1ps
`default_nettype none

module psm_num_fmt (
  input wire logic signed [31:0] i_value,
  input wire logic i_is32,
  input wire logic i_hex,
  input wire logic i_high,
  input wire logic i_split,
  output psm_pkg::psm_glyphs_t o_seg,
  output logic o_neg
);
  // Shift-and-add-3; cheap at panel rates, no divider needed
  function automatic logic [39:0] bin2bcd(input logic [31:0] b);
    logic [39:0] r;
    r = '0;
    for (int i = 31; i >= 0; i--) begin
      for (int k = 0; k < 10; k++) begin
        if (r[4*k+:4] > 4'h4) r[4*k+:4] = r[4*k+:4] + 4'h3;
      end
      r = {r[38:0], b[i]};
    end
    return r;
  endfunction

  logic [31:0] mag;
  logic [39:0] bcd;
  logic [19:0] dsel;
  logic [15:0] nib;

  // Code 17 halves are independent unsigned fields
  assign o_neg = !i_hex && !i_split && i_value[31]; // R9
  assign mag = i_split ? {16'h0, (i_high ? i_value[31:16] : i_value[15:0])} :
               (o_neg ? 32'(-i_value) : 32'(i_value)); // R19
  assign bcd = bin2bcd(mag);
  assign dsel = (i_is32 && !i_split && i_high) ? bcd[39:20] : bcd[19:0];
  assign nib = (i_is32 && i_high) ? i_value[31:16] : i_value[15:0];

  always_comb begin
    o_seg = '0;
    if (i_hex) begin
      o_seg[4] = !i_is32 ? psm_pkg::SEG_BLANK : (i_high ? psm_pkg::SEG_H : psm_pkg::SEG_L);
      for (int d = 0; d < 4; d++) begin
        o_seg[d] = psm_pkg::hex_seg(nib[4*d+:4]);
      end
    end else begin
      for (int d = 0; d < 5; d++) begin
        o_seg[d] = psm_pkg::hex_seg(dsel[4*d+:4]);
      end
      if (i_is32 && i_high) o_seg[0] = o_seg[0] | psm_pkg::SEG_DP; // R8
      if (o_neg) begin
        o_seg[4] = o_seg[4] | psm_pkg::SEG_DP; // R9
        o_seg[3] = o_seg[3] | psm_pkg::SEG_DP;
      end
    end
  end
endmodule

`default_nettype wire

// ==== sim/psm_keypad_model.sv ====
// Operator keypad model: raises one key pin for a chosen number of cycles.
// Assumes the caller sits at a falling edge; pins move only on falling edges.
`timescale 1ns/1ps
`default_nettype none

module psm_keypad_model (
  input wire logic i_clk,
  output var psm_pkg::psm_keys_s o_keys
);
  initial o_keys = '0;

  // Short holds act as taps, long holds as held keys
  task automatic press(input int idx, input int hold);
    @(negedge i_clk);
    o_keys[idx] = 1'b1;
    repeat (hold) @(negedge i_clk);
    o_keys[idx] = 1'b0;
  endtask
endmodule

`default_nettype wire

// ==== sim/panel_status_monitor_display_tb.sv ====
// Bench for the panel display top: boot, monitor views, edits and saves, alarms.
// Assumes the keypad model drives the key pins and the bench plays the parameter store.
`timescale 1ns/1ps
`default_nettype none

module panel_status_monitor_display_tb;
  localparam int SHOW = 20;
  localparam int HOLD = 30;
  localparam int IDLE = 50;
  localparam int K_MODE = 4;
  localparam int K_SET = 3;
  localparam int K_SHIFT = 2;
  localparam int K_UP = 1;
  localparam int K_DOWN = 0;
  localparam logic [7:0] HEXSEG [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h07,
    8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};
  // Bits {read_only,pw_ok,servo_on,run_locked,repower,reserved,over}
  localparam logic [6:0] CASES [8] = '{7'h20, 7'h40, 7'h00, 7'h38, 7'h21, 7'h22, 7'h24, 7'h30};

  logic clk, rstn, edit_start, pw_ok, servo_on, val_res, alarm_new, alarm_act, msel_wr;
  logic signed [31:0] edit_init, mon_value, wr_value, v;
  logic [11:0] alarm_code;
  logic [7:0] msel_data, d;
  logic [4:0] mon_sel, sel_exp;
  logic wr_stb, alarm_view;
  logic [6:0] b;
  logic [40:0] r;
  psm_pkg::psm_keys_s keys;
  psm_pkg::psm_attr_s attr, a;
  psm_pkg::psm_glyphs_t seg;
  int seed, failures, n_checks, n_stb;

  psm_keypad_model psm_keypad_model_i (.i_clk(clk), .o_keys(keys));

  psm_panel_top #(.P_SHOW_CYC(SHOW), .P_HOLD_CYC(HOLD), .P_IDLE_CYC(IDLE), .P_BLINK_CYC(4)) psm_panel_top_i (
    .i_clk(clk), .i_rstn(rstn), .i_keys(keys), .i_edit_start(edit_start), .i_edit_init(edit_init),
    .i_attr(attr), .i_pw_ok(pw_ok), .i_servo_on(servo_on), .i_val_reserved(val_res),
    .i_alarm_new(alarm_new), .i_alarm_act(alarm_act), .i_alarm_code(alarm_code), .i_msel_wr(msel_wr),
    .i_msel_data(msel_data), .i_mon_value(mon_value), .o_mon_sel(mon_sel), .o_wr_stb(wr_stb),
    .o_wr_value(wr_value), .o_alarm_view(alarm_view), .o_seg(seg));

  always #50 clk = ~clk;

  always @(posedge clk) begin
    if (wr_stb === 1'b1) n_stb++;
  end

  function automatic logic [39:0] view(input logic signed [31:0] x, input logic is32, input logic hx,
                                       input logic hi);
    longint m;
    logic [39:0] g;
    logic [15:0] h;
    h = hi ? x[31:16] : x[15:0];
    m = (x < 0) ? -longint'(x) : longint'(x);
    if (is32 && hi) m = m / 100000;
    for (int i = 0; i < 5; i++) begin
      g[i*8 +: 8] = hx ? HEXSEG[h[(i%4)*4 +: 4]] : HEXSEG[4'(m % 10)];
      m = m / 10;
    end
    if (hx) g[39:32] = is32 ? (hi ? psm_pkg::SEG_H : psm_pkg::SEG_L) : psm_pkg::SEG_BLANK;
    if (!hx && is32 && hi) g[7] = 1'b1;
    // Hex views carry no sign
    if (!hx && x < 0) {g[39], g[31]} = 2'b11;
    return g;
  endfunction

  function automatic logic [40:0] exp_res(input logic [6:0] c, input logic signed [31:0] x);
    if (c[6]) return {1'b0, psm_pkg::TXT_RO};
    if (!c[5]) return {1'b0, psm_pkg::TXT_LOCK};
    if (c[4] && c[3]) return {1'b0, psm_pkg::TXT_SON};
    if (c[1] || x > 1000 || x < -1000) return {1'b0, psm_pkg::TXT_OOR};
    return c[2] ? {1'b1, psm_pkg::TXT_PON} : {1'b1, psm_pkg::TXT_SAVED};
  endfunction

  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic key(input int idx, input int hold);
    psm_keypad_model_i.press(idx, hold);
    tick(6);
  endtask

  task automatic mon(input logic signed [31:0] x, input logic is32, input logic hx, input logic hi);
    mon_value = x;
    tick(2);
    chk("o_seg", view(x, is32, hx, hi), seg);
  endtask

  task automatic wr_sel(input logic [7:0] dv);
    msel_data = dv;
    msel_wr = 1'b1;
    tick(1);
    msel_wr = 1'b0;
    tick(1);
  endtask

  task automatic edit_begin(input logic signed [31:0] x, input psm_pkg::psm_attr_s at);
    edit_init = x;
    attr = at;
    edit_start = 1'b1;
    tick(1);
    edit_start = 1'b0;
    tick(2);
  endtask

  // Result text, strobe count and stored value, then the return to the monitor view
  task automatic save(input logic [40:0] res, input logic signed [31:0] x);
    int n0;
    n0 = n_stb;
    key(K_SET, 3);
    chk("o_seg", res[39:0], seg);
    chk("o_wr_stb", 40'(res[40]), 40'(n_stb - n0));
    if (res[40]) chk("o_wr_value", 40'(x), 40'(wr_value));
    tick(SHOW + 2);
    chk("o_seg", view(mon_value, 1'b0, 1'b0, 1'b0), seg);
  endtask

  task automatic tally_and_finish;
    if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish;
  end

  initial begin
    seed = 22;
    {clk, rstn, edit_start, pw_ok, servo_on, val_res, alarm_new, alarm_act, msel_wr} = '0;
    {failures, n_checks, n_stb} = '0;
    {edit_init, alarm_code, msel_data, attr} = '0;
    mon_value = $random(seed);
    sel_exp = 5'h00;
    tick(10);
    chk("o_seg", 40'h0, seg);
    chk("outputs", 40'h0, 40'({mon_sel, wr_stb, wr_value, alarm_view}));
    tick(2);
    rstn = 1'b1;
    tick(1);
    chk("o_seg", {psm_pkg::SEG_P, psm_pkg::SEG_N, psm_pkg::SEG_MINUS, HEXSEG[0], HEXSEG[0]}, seg);
    tick(SHOW + 2);
    chk("o_seg", view(mon_value, 1'b1, 1'b0, 1'b0), seg);
    mon(-32'sd1234567890, 1'b1, 1'b0, 1'b0);
    key(K_SHIFT, 3);
    mon(-32'sd1234567890, 1'b1, 1'b0, 1'b1);
    key(K_SET, 3);
    mon($random(seed), 1'b1, 1'b1, 1'b1);
    key(K_SHIFT, 3);
    mon($random(seed), 1'b1, 1'b1, 1'b0);
    key(K_SET, 3);
    mon($random(seed), 1'b1, 1'b0, 1'b0);
    for (int k = 0; k < 40; k++) begin
      d = (k < 20) ? 8'(k) : 8'($random(seed));
      wr_sel(d);
      if (d <= 8'd18) sel_exp = d[4:0];
      chk("o_mon_sel", 40'(sel_exp), 40'(mon_sel));
    end
    wr_sel(8'd5);
    key(K_UP, 3);
    chk("o_mon_sel", 40'(5'd6), 40'(mon_sel));
    key(K_DOWN, 4);
    chk("o_mon_sel", 40'(5'd5), 40'(mon_sel));
    wr_sel(8'd7);
    for (int k = 0; k < 8; k++) mon(k == 0 ? -32'sd32768 : $signed(16'($random(seed))), 1'b0, 1'b0, 1'b0);
    key(K_SET, 3);
    mon(-32'sd5, 1'b0, 1'b1, 1'b0);
    key(K_SET, 3);
    mon(32'sd1234, 1'b0, 1'b0, 1'b0);
    // Code 17 halves are two unsigned fields, high half marked by the point
    wr_sel(8'd17);
    v = {16'($random(seed)), 16'($random(seed))};
    mon_value = v;
    tick(2);
    chk("o_seg", view({16'h0, v[15:0]}, 1'b0, 1'b0, 1'b0), seg);
    key(K_SHIFT, 3);
    chk("o_seg", view({16'h0, v[31:16]}, 1'b0, 1'b0, 1'b0) | 40'h80, seg);
    wr_sel(8'd18);
    mon(-32'sd5000, 1'b0, 1'b0, 1'b0);
    for (int k = 0; k < 17; k++) begin
      b = (k < 8) ? CASES[k] : 7'($random(seed));
      v = b[0] ? 32'sd1000 : 32'($random(seed) % 1000);
      a = '{read_only: b[6], run_locked: b[3], repower: b[2], is32: 1'b0, hex: 1'b0, min: -32'sd1000,
            max: 32'sd1000};
      pw_ok = b[5];
      servo_on = b[4];
      val_res = b[1];
      edit_begin(v, a);
      key(K_UP, 3);
      r = exp_res(b, v + 32'sd1);
      save(r, v + 32'sd1);
      {servo_on, val_res} = 2'b00;
    end
    pw_ok = 1'b1;
    a = '{read_only: 1'b0, run_locked: 1'b0, repower: 1'b0, is32: 1'b0, hex: 1'b0, min: -32'sd1000,
          max: 32'sd1000};
    edit_begin(32'sd123, a);
    key(K_SHIFT, HOLD + 5);
    key(K_SHIFT, 2);
    key(K_UP, 2);
    save({1'b1, psm_pkg::TXT_SAVED}, -32'sd113);
    a.min = 32'sd0;
    edit_begin(32'sd123, a);
    key(K_SHIFT, HOLD + 5);
    save({1'b1, psm_pkg::TXT_SAVED}, 32'sd123);
    alarm_code = 12'($random(seed));
    alarm_act = 1'b1;
    alarm_new = 1'b1;
    tick(1);
    alarm_new = 1'b0;
    chk("o_alarm_view", 40'h1, 40'(alarm_view));
    tick(1);
    chk("o_seg", {psm_pkg::SEG_A, psm_pkg::SEG_L, HEXSEG[alarm_code[11:8]], HEXSEG[alarm_code[7:4]],
                  HEXSEG[alarm_code[3:0]]}, seg);
    key(K_MODE, 3);
    chk("o_alarm_view", 40'h0, 40'(alarm_view));
    tick(IDLE - 20);
    chk("o_alarm_view", 40'h0, 40'(alarm_view));
    for (int n = 0; n < 40 && alarm_view !== 1'b1; n++) tick(1);
    chk("o_alarm_view", 40'h1, 40'(alarm_view));
    tally_and_finish;
  end
endmodule

`default_nettype wire
